// ---- inc/sfq_pkg.sv ----
// Constants, field layouts and state encodings for the serial flash read and lock-query block.
// Function
// - After the fast-read command, 24 address bits and a dummy byte sampled on rising clock.
// - After the dummy byte, array data shifts out on falling clock edges.
// - Reading starts at any address and advances by one per output byte.
// - The read address wraps from the top location to zero and streaming continues.
// - Raising chip select ends a fast read and releases the output.
// - A fast read arriving during a busy cycle is ignored, cycle untouched.
// - Address bits 23 to 20 of a read are ignored.
// - Lock query takes a 24-bit address anywhere within the sector of interest.
// - Lock query address bits are captured on rising clock edges.
// - After the address, the sector lock byte shifts out on falling edges.
// - Raising chip select during lock query output finishes the instruction.
// - A lock query during a busy cycle is rejected without disturbing it.
// - A set lock-down bit freezes write-lock and lock-down until reset.
// - A set write-lock bit blocks write, program and erase in that sector.
// - With lock-down clear, new lock values may be written.
// - With write-lock clear, write, program and erase proceed normally.
// - Legacy variant: a set subsector write-lock blocks that subsector.
// - Legacy subsector bits apply to first and last sectors only, else zero.
// - Busy flag is one throughout a self-timed cycle and zero afterwards.
// - Lock bits are volatile and update at once, without a timed cycle.
package sfq_pkg;

  // Array geometry: 20 live address bits, 16 sectors of 16 subsectors.
  localparam int ADDR_W = 24;
  localparam int ARR_W = 20;
  localparam int SEC_MSB = 19;
  localparam int SEC_LSB = 16;
  localparam int SUB_MSB = 15;
  localparam int SUB_LSB = 12;
  localparam logic [3:0] SEC_FIRST = 4'h0;
  localparam logic [3:0] SEC_LAST = 4'hF;

  // Lock byte field positions.
  localparam int LB_WLOCK = 0;
  localparam int LB_LDOWN = 1;
  localparam int LB_SUB_WLOCK = 2;
  localparam int LB_SUB_LDOWN = 3;
  localparam logic [1:0] LOCK_RESET = 2'h0;

  // Default command byte values; arbitrary, override at the top level.
  localparam logic [7:0] DEF_FAST_READ_CMD = 8'h0B;
  localparam logic [7:0] DEF_LOCK_QUERY_CMD = 8'hE8;

  // Bit counts of each serial phase.
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [4:0] DUMMY_BITS = 5'h08;
  localparam logic [2:0] LAST_OUT_BIT = 3'h7;

  typedef enum logic [2:0] {
    SFQ_CMD = 3'b000,
    SFQ_ADDR = 3'b001,
    SFQ_DUMMY = 3'b010,
    SFQ_DATA = 3'b011,
    SFQ_LOCKOUT = 3'b100,
    SFQ_IGNORE = 3'b101
  } sfq_state_e;

endpackage

// ---- design/sfq_sync.sv ----
// Two-flop synchroniser for pin inputs entering the CLOCK domain.
`timescale 1ns/100ps
module sfq_sync #(
  parameter int W = 3
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [W-1:0] ASYNC_IN,
  output logic [W-1:0] SYNC_OUT
);

  logic [W-1:0] stage1;

  // The first stage feeds only the second; both reset to zero, which for SEL_N is the selected level.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      stage1 <= '0;
      SYNC_OUT <= '0;
    end else begin
      stage1 <= ASYNC_IN;
      SYNC_OUT <= stage1;
    end
  end

endmodule

// ---- design/sfq_top.sv ----
// Serial fast-read and lock-query engine with volatile per-sector lock registers.
`timescale 1ns/100ps
module sfq_top
  import sfq_pkg::*;
#(
  parameter logic [7:0] FAST_READ_CMD = DEF_FAST_READ_CMD,
  parameter logic [7:0] LOCK_QUERY_CMD = DEF_LOCK_QUERY_CMD,
  parameter bit LEGACY = 1'b0
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic SEL_N,
  input wire logic SCLK,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE,
  output logic [ARR_W-1:0] ARRAY_ADDR,
  input wire logic [7:0] ARRAY_DATA,
  input wire logic CYCLE_START,
  input wire logic CYCLE_DONE,
  output logic CYCLE_BUSY_FLAG,
  input wire logic LOCK_WR_STB,
  input wire logic [ADDR_W-1:0] LOCK_WR_ADDR,
  input wire logic [7:0] LOCK_WR_DATA,
  output logic LOCK_WR_REFUSED,
  input wire logic [ADDR_W-1:0] PROT_ADDR,
  output logic PROT_BLOCK
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and serial clock edge detection.

  logic [2:0] pins_sync;
  logic sel_n_s;
  logic sclk_s;
  logic sdi_s;
  logic sclk_d;
  wire sclk_rise;
  wire sclk_fall;

  sfq_sync #(.W(3)) u_sync (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .ASYNC_IN({SEL_N, SCLK, SDI}),
    .SYNC_OUT(pins_sync)
  );

  // Named taps of the synchroniser output.
  assign sel_n_s = pins_sync[2];
  assign sclk_s = pins_sync[1];
  assign sdi_s = pins_sync[0];

  // Edges are found on the synchronised copy, so SCLK must stay well below CLOCK/4.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
    end
  end

  // One-cycle strobes at each synchronised serial clock edge.
  assign sclk_rise = sclk_s & ~sclk_d;
  assign sclk_fall = ~sclk_s & sclk_d;

  //////////////////////////////////////////////////////////////////////////////
  // Lock register storage and lookup helpers.

  // Per-sector write-lock and lock-down bits.
  logic [1:0] sec_lock [16];
  // Legacy subsector bits for the first (index 0-15) and last (16-31) sectors.
  logic [1:0] sub_lock [32];

  // True when a sector carries subsector bits in the legacy variant.
  function automatic logic edge_sector(input logic [ADDR_W-1:0] a);
    return LEGACY && (a[SEC_MSB:SEC_LSB] == SEC_FIRST || a[SEC_MSB:SEC_LSB] == SEC_LAST);
  endfunction

  // Subsector slot index for an address in the first or last sector.
  function automatic logic [4:0] sub_index(input logic [ADDR_W-1:0] a);
    return {(a[SEC_MSB:SEC_LSB] == SEC_LAST), a[SUB_MSB:SUB_LSB]};
  endfunction

  // Assembles the lock byte seen by a query; the upper nibble is reserved.
  function automatic logic [7:0] lock_byte(input logic [ADDR_W-1:0] a, input logic [1:0] sec,
                                           input logic [1:0] sub);
    logic [1:0] sub_vis;
    sub_vis = edge_sector(a) ? sub : 2'b00;
    return {4'h0, sub_vis, sec};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Lock register update and write-protection query.

  wire [3:0] wr_sec;
  wire [4:0] wr_sub;
  wire sec_frozen;
  wire sub_frozen;
  wire wr_refuse;
  wire [7:0] prot_lb;
  wire [1:0] prot_sec;
  wire [1:0] prot_sub;

  // Target slot decode for a lock update; busy or sector lock-down refuses it.
  assign wr_sec = LOCK_WR_ADDR[SEC_MSB:SEC_LSB];
  assign wr_sub = sub_index(LOCK_WR_ADDR);
  assign sec_frozen = sec_lock[wr_sec][LB_LDOWN];
  assign sub_frozen = sec_frozen | sub_lock[wr_sub][LB_LDOWN];
  assign wr_refuse = CYCLE_BUSY_FLAG | sec_frozen;
  // Array elements are read here rather than inside the function, so a lock write
  // re-evaluates the lookup even while the address stands still.
  assign prot_sec = sec_lock[PROT_ADDR[SEC_MSB:SEC_LSB]];
  assign prot_sub = sub_lock[sub_index(PROT_ADDR)];
  assign prot_lb = lock_byte(PROT_ADDR, prot_sec, prot_sub);

  // Lock bits are plain flops: a write lands on the next edge, no timed cycle.
  // Legacy subsector bits have their own lock-down on top of the sector's.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 16; i++) begin
        sec_lock[i] <= LOCK_RESET;
      end
      for (int i = 0; i < 32; i++) begin
        sub_lock[i] <= LOCK_RESET;
      end
    end else if (LOCK_WR_STB && !CYCLE_BUSY_FLAG) begin
      if (!sec_frozen) begin
        sec_lock[wr_sec] <= LOCK_WR_DATA[LB_LDOWN:LB_WLOCK];
      end
      if (edge_sector(LOCK_WR_ADDR) && !sub_frozen) begin
        sub_lock[wr_sub] <= LOCK_WR_DATA[LB_SUB_LDOWN:LB_SUB_WLOCK];
      end
    end
  end

  // Refusal pulse and registered protection answer for the program engine.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      LOCK_WR_REFUSED <= 1'b0;
      PROT_BLOCK <= 1'b0;
    end else begin
      LOCK_WR_REFUSED <= LOCK_WR_STB & wr_refuse;
      PROT_BLOCK <= prot_lb[LB_WLOCK] | prot_lb[LB_SUB_WLOCK];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Busy flag for self-timed cycles.

  // A start in the same cycle as a done wins, so a chained cycle is never missed.
  // The sequencer looks at busy only when a command byte completes.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      CYCLE_BUSY_FLAG <= 1'b0;
    end else if (CYCLE_START) begin
      CYCLE_BUSY_FLAG <= 1'b1;
    end else if (CYCLE_DONE) begin
      CYCLE_BUSY_FLAG <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial instruction sequencer.

  sfq_state_e state;
  sfq_state_e next_state;
  logic [4:0] bit_cnt;
  logic [2:0] out_cnt;
  logic [ADDR_W-1:0] in_sh;
  logic [7:0] out_sh;
  logic is_query;
  logic [ADDR_W-1:0] query_addr;

  wire [ADDR_W-1:0] in_next;
  wire [4:0] bit_next;
  wire phase_done;
  wire [7:0] cmd_byte;
  wire busy_reject;
  wire [7:0] out_src;
  wire out_state;
  wire [1:0] qry_sec;
  wire [1:0] qry_sub;
  wire [7:0] qry_lb;

  // Shift-in, counting and output-source decode shared by both instructions.
  assign in_next = {in_sh[ADDR_W-2:0], sdi_s};
  assign bit_next = bit_cnt + 5'h01;
  assign cmd_byte = in_next[7:0];
  assign busy_reject = CYCLE_BUSY_FLAG;
  assign qry_sec = sec_lock[query_addr[SEC_MSB:SEC_LSB]];
  assign qry_sub = sub_lock[sub_index(query_addr)];
  assign qry_lb = lock_byte(query_addr, qry_sec, qry_sub);
  assign out_src = is_query ? qry_lb : ARRAY_DATA;
  assign out_state = (state == SFQ_DATA) || (state == SFQ_LOCKOUT);

  // Phase length depends on the state.
  assign phase_done = sclk_rise && (
    (state == SFQ_CMD && bit_next == CMD_BITS) ||
    (state == SFQ_ADDR && bit_next == ADDR_BITS) ||
    (state == SFQ_DUMMY && bit_next == DUMMY_BITS));

  // Next-state decode; deselect always returns to command capture.
  always_comb begin
    next_state = state;
    if (sel_n_s) begin
      next_state = SFQ_CMD;
    end else if (phase_done) begin
      case (state)
        SFQ_CMD: begin
          if (busy_reject) begin
            next_state = SFQ_IGNORE;
          end else if (cmd_byte == FAST_READ_CMD || cmd_byte == LOCK_QUERY_CMD) begin
            next_state = SFQ_ADDR;
          end else begin
            next_state = SFQ_IGNORE;
          end
        end
        SFQ_ADDR: begin
          next_state = is_query ? SFQ_LOCKOUT : SFQ_DUMMY;
        end
        SFQ_DUMMY: begin
          next_state = SFQ_DATA;
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end

  // State, input shifting and bit counting.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state <= SFQ_CMD;
      bit_cnt <= 5'h00;
      in_sh <= '0;
      is_query <= 1'b0;
      query_addr <= '0;
    end else begin
      state <= next_state;
      if (sel_n_s || phase_done) begin
        bit_cnt <= 5'h00;
      end else if (sclk_rise) begin
        bit_cnt <= bit_next;
      end
      if (sclk_rise && !sel_n_s) begin
        in_sh <= in_next;
      end
      if (phase_done && state == SFQ_CMD) begin
        is_query <= (cmd_byte == LOCK_QUERY_CMD);
      end
      if (phase_done && state == SFQ_ADDR) begin
        query_addr <= in_next;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Array address counter.

  // Only the low 20 bits are kept, so the top nibble is dropped and the counter wraps.
  // The load and the step never coincide, as they belong to different states.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ARRAY_ADDR <= '0;
    end else if (phase_done && state == SFQ_ADDR && !is_query) begin
      ARRAY_ADDR <= in_next[ARR_W-1:0];
    end else if (state == SFQ_DATA && sclk_fall && !sel_n_s && out_cnt == LAST_OUT_BIT) begin
      ARRAY_ADDR <= ARRAY_ADDR + 20'h00001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output shifter.

  // A new byte is loaded at each byte boundary; the array has many CLOCK cycles
  // between the address change and the next falling SCLK edge to settle.
  // A partial byte at deselect is dropped; the next frame restarts at bit 7.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      out_cnt <= 3'h0;
      out_sh <= 8'h00;
      SDO <= 1'b0;
      SDO_OE <= 1'b0;
    end else if (sel_n_s || !out_state) begin
      out_cnt <= 3'h0;
      SDO_OE <= 1'b0;
    end else if (sclk_fall) begin
      out_cnt <= out_cnt + 3'h1;
      SDO_OE <= 1'b1;
      if (out_cnt == 3'h0) begin
        SDO <= out_src[7];
        out_sh <= {out_src[6:0], 1'b0};
      end else begin
        SDO <= out_sh[7];
        out_sh <= {out_sh[6:0], 1'b0};
      end
    end
  end

endmodule

// ---- verification/sfq_asserts.sv ----
// Port-level assertions for the serial read and lock-query block.
`timescale 1ns/100ps
module sfq_asserts
  import sfq_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic SEL_N,
  input wire logic SCLK,
  input wire logic SDO,
  input wire logic SDO_OE,
  input wire logic [ARR_W-1:0] ARRAY_ADDR,
  input wire logic CYCLE_START,
  input wire logic CYCLE_DONE,
  input wire logic CYCLE_BUSY_FLAG,
  input wire logic LOCK_WR_STB,
  input wire logic LOCK_WR_REFUSED
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////
  // Raw clock rises in this frame; output before the header ends is a framing fault.
  logic [7:0] rises;
  logic sclk_q;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rises <= 8'h00;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= SCLK;
      rises <= SEL_N ? 8'h00 : rises + {7'h00, SCLK & ~sclk_q};
    end
  end
  sequence sel_idle_s;
    SEL_N [*6];
  endsequence
  ////////////////////////////////////////
  busy_set_a: assert property (CYCLE_START |=> CYCLE_BUSY_FLAG)
    else $error("busy flag not set");
  busy_clear_a: assert property (CYCLE_DONE && !CYCLE_START |=> !CYCLE_BUSY_FLAG)
    else $error("busy flag not cleared");
  lock_busy_refuse_a: assert property (LOCK_WR_STB && CYCLE_BUSY_FLAG |=> LOCK_WR_REFUSED)
    else $error("lock update not refused while busy");
  refuse_cause_a: assert property (!LOCK_WR_STB |=> !LOCK_WR_REFUSED)
    else $error("refusal without request");
  oe_release_a: assert property (sel_idle_s |-> !SDO_OE)
    else $error("output driven while deselected");
  oe_after_hdr_a: assert property ($rose(SDO_OE) |-> rises >= 8'h20)
    else $error("output before header complete");
  sdo_fall_a: assert property (SDO_OE && $changed(SDO) |-> !SCLK)
    else $error("output changed while clock high");
  addr_step_a: assert property (
    SDO_OE && $past(SDO_OE) && $changed(ARRAY_ADDR) |->
      ARRAY_ADDR == $past(ARRAY_ADDR) + 20'h1)
    else $error("read address did not step by one");
endmodule

// ---- verification/sfq_host_model.sv ----
// Host serial master that frames instructions on the select, clock and data pins.
`timescale 1ns/100ps
module sfq_host_model (
  input wire logic clk,
  output logic sel_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // Data moves with the falling clock; output is read just before the next fall, long
  // after the device has settled it. The clock rests low outside frames.
  task automatic frame(input logic [7:0] cmd, input logic [23:0] addr, input int total,
                       output logic [23:0] got, output logic oe);
    logic [39:0] hdr;
    hdr = {cmd, addr, 8'h00};
    got = 24'h0;
    oe = 1'b0;
    @(negedge clk) sel_n = 1'b0;
    for (int i = 0; i < total; i++) begin
      sclk = 1'b0;
      sdi = (i < 40) ? hdr[39-i] : ~sdi;
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      got = {got[22:0], sdo};
      oe = oe | sdo_oe;
    end
    sclk = 1'b0;
    repeat (4) @(negedge clk);
    sel_n = 1'b1;
    sdi = ~sdi;
    repeat (8) @(negedge clk);
  endtask
endmodule

// ---- verification/test_sfq_top.sv ----
// Self-checking bench: serial reads, lock updates, busy refusals and protection.
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module test_sfq_top;
  import sfq_pkg::*;
  logic clk, rst_n, sel_n, sclk, sdi, sdo, sdo_oe, cs, cd, busy, stb, refused, pblk, oe;
  logic sel2_n, sclk2, sdi2, sdo2, sdo2_oe, refused2, pblk2, sdo_pin, sdo2_pin;
  logic [19:0] aa, aa2;
  logic [7:0] wd;
  logic [23:0] wa, pa, got;
  int n_fail, checks_done;
  // Array stand-in: a pattern that differs at every address near the wrap.
  function automatic logic [7:0] mem(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ {a[19:16], 4'h3};
  endfunction
  // A released output pin shows the inverse of its last value, so stray sampling fails.
  assign sdo_pin = sdo_oe ? sdo : ~sdo;
  assign sdo2_pin = sdo2_oe ? sdo2 : ~sdo2;
  sfq_host_model host_u (.clk(clk), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo_pin),
    .sdo_oe(sdo_oe));
  sfq_host_model host_lg_u (.clk(clk), .sel_n(sel2_n), .sclk(sclk2), .sdi(sdi2),
    .sdo(sdo2_pin), .sdo_oe(sdo2_oe));
  sfq_top dut_u (.CLOCK(clk), .RST_N(rst_n), .SEL_N(sel_n), .SCLK(sclk), .SDI(sdi),
    .SDO(sdo), .SDO_OE(sdo_oe), .ARRAY_ADDR(aa), .ARRAY_DATA(mem(aa)), .CYCLE_START(cs),
    .CYCLE_DONE(cd), .CYCLE_BUSY_FLAG(busy), .LOCK_WR_STB(stb), .LOCK_WR_ADDR(wa),
    .LOCK_WR_DATA(wd), .LOCK_WR_REFUSED(refused), .PROT_ADDR(pa), .PROT_BLOCK(pblk));
  // Legacy variant: shares the same-clock ports and has a serial host of its own.
  sfq_top #(.LEGACY(1'b1)) dut_lg_u (.CLOCK(clk), .RST_N(rst_n), .SEL_N(sel2_n),
    .SCLK(sclk2), .SDI(sdi2), .SDO(sdo2), .SDO_OE(sdo2_oe), .ARRAY_ADDR(aa2),
    .ARRAY_DATA(mem(aa2)), .CYCLE_START(cs), .CYCLE_DONE(cd), .CYCLE_BUSY_FLAG(),
    .LOCK_WR_STB(stb), .LOCK_WR_ADDR(wa), .LOCK_WR_DATA(wd), .LOCK_WR_REFUSED(refused2),
    .PROT_ADDR(pa), .PROT_BLOCK(pblk2));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task end_of_test;
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task rst;
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task cyc(input logic s, input logic d);
    @(negedge clk) {cs, cd} = {s, d};
    @(negedge clk) {cs, cd} = 2'b00;
    @(negedge clk);
  endtask
  // The refusal pulse stands only for the cycle after the strobe edge.
  task lock_wr(input logic [23:0] a, input logic [7:0] d, input logic r);
    @(negedge clk) {wa, wd, stb} = {a, d, 1'b1};
    @(negedge clk) stb = 1'b0;
    `CHK(refused, r)
    `CHK(refused2, r)
    @(negedge clk);
    `CHK(refused, 1'b0)
  endtask
  task query(input logic [23:0] a, input logic [7:0] e, input logic eoe);
    host_u.frame(DEF_LOCK_QUERY_CMD, a, 48, got, oe);
    `CHK(oe, eoe)
    if (eoe) `CHK(got[15:0], {e, e})
  endtask
  task prot(input logic [23:0] a, input logic e, input logic el);
    @(negedge clk) pa = a;
    @(negedge clk);
    `CHK(pblk, e)
    `CHK(pblk2, el)
  endtask
  // Hang guard: the whole run is far shorter than this.
  initial begin
    #300000;
    n_fail++;
    end_of_test();
  end
  initial begin
    {cs, cd, stb, wa, wd, pa, n_fail, checks_done} = '0;
    rst();
    query(24'h050000, 8'h00, 1'b1);
    host_u.frame(DEF_FAST_READ_CMD, 24'hAFFFFE, 64, got, oe);
    `CHK(got, {mem(20'hFFFFE), mem(20'hFFFFF), mem(20'h00000)})
    host_u.frame(DEF_FAST_READ_CMD, 24'h000100, 16, got, oe);
    `CHK(oe, 1'b0)
    lock_wr(24'h05ABCD, 8'hF1, 1'b0);
    query(24'h05FFFF, 8'h01, 1'b1);
    prot(24'h051234, 1'b1, 1'b1);
    prot(24'h061234, 1'b0, 1'b0);
    lock_wr(24'h050000, 8'h02, 1'b0);
    lock_wr(24'h050010, 8'h01, 1'b1);
    query(24'h050001, 8'h02, 1'b1);
    prot(24'h051234, 1'b0, 1'b0);
    cyc(1'b1, 1'b1);
    `CHK(busy, 1'b1)
    host_u.frame(DEF_FAST_READ_CMD, 24'h000000, 64, got, oe);
    `CHK(oe, 1'b0)
    query(24'h050000, 8'h00, 1'b0);
    lock_wr(24'h060000, 8'h01, 1'b1);
    `CHK(busy, 1'b1)
    cyc(1'b0, 1'b1);
    `CHK(busy, 1'b0)
    prot(24'h061234, 1'b0, 1'b0);
    rst();
    query(24'h050000, 8'h00, 1'b1);
    lock_wr(24'h0F3000, 8'h0C, 1'b0);
    prot(24'h0F3456, 1'b0, 1'b1);
    prot(24'h0F4456, 1'b0, 1'b0);
    lock_wr(24'h0F3000, 8'h00, 1'b0);
    prot(24'h0F3456, 1'b0, 1'b1);
    host_lg_u.frame(DEF_LOCK_QUERY_CMD, 24'h0F3FFF, 48, got, oe);
    `CHK(got[15:0], 16'h0C0C)
    lock_wr(24'h053000, 8'h0C, 1'b0);
    host_lg_u.frame(DEF_LOCK_QUERY_CMD, 24'h053000, 48, got, oe);
    `CHK(got[15:0], 16'h0000)
    `CHK(oe, 1'b1)
    query(24'h0F3000, 8'h00, 1'b1);
    end_of_test();
  end
endmodule
bind sfq_top sfq_asserts chk_u (.CLOCK(CLOCK), .RST_N(RST_N), .SEL_N(SEL_N), .SCLK(SCLK),
  .SDO(SDO), .SDO_OE(SDO_OE), .ARRAY_ADDR(ARRAY_ADDR), .CYCLE_START(CYCLE_START),
  .CYCLE_DONE(CYCLE_DONE), .CYCLE_BUSY_FLAG(CYCLE_BUSY_FLAG), .LOCK_WR_STB(LOCK_WR_STB),
  .LOCK_WR_REFUSED(LOCK_WR_REFUSED));
